//--- pkg/cadp_defs.vh
// What this block does
// - Sixteen-bit datapath doing two's complement add, subtract, shifts and logic.
// - Operations update carry, zero, negative, overflow and digit-carry status flags.
// - On subtraction carry and digit carry mean no borrow and no digit borrow.
// - Add, subtract, logic and shift operations run in byte or word width, chosen by the command.
// - Operands come from working registers or memory; results go likewise.
// - Multiplier works on seventeen by seventeen bit operands.
// - Multiply modes: signed, unsigned, mixed, five-bit literal, and eight by eight.
// - Divide signed or unsigned, 32 or 16 bit dividend by 16 bit divisor.
// - Divide leaves quotient in working register zero, remainder in register one.
// - Divisor from any register; 32-bit dividend from an even pair, odd high.
// - Divide iterates one cycle per divisor bit, same for both dividend sizes.
// - Single-bit and multibit shifts; a multibit shift takes one cycle.
// - Barrel shifter moves up to fifteen places right or left in one cycle.
// - Multibit shifts accept only register operands and register destinations.
// - Shifts are arithmetic right, left, and logical right with zero fill.
// - A divide takes nineteen cycles and may be stopped at any cycle.
// - Every multiply mode completes in a single cycle.
// - Digit carry is carry out of bit four for bytes, bit eight for words.
// - Sticky zero: non-zero result clears the flag, zero result leaves it.
`ifndef CADP_DEFS_VH
`define CADP_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CADP_OFF_CMD      8'h00
`define CADP_OFF_STATUS   8'h04
`define CADP_OFF_MEMDATA  8'h08
`define CADP_OFF_RESULT   8'h0c
`define CADP_OFF_WREG     8'h40

// ----------------------------------------------------------------
// Command fields
// ----------------------------------------------------------------
`define CADP_CMD_OP_LSB   0
`define CADP_CMD_BYTE     4
`define CADP_CMD_SRCMEM   5
`define CADP_CMD_DSTMEM   6
`define CADP_CMD_RA_LSB   8
`define CADP_CMD_RB_LSB   12
`define CADP_CMD_RD_LSB   16
`define CADP_CMD_LIT_LSB  20
`define CADP_CMD_STICKY   25
`define CADP_CMD_DIV32    26
`define CADP_CMD_ABORT    31

// ----------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------
`define CADP_ST_C         0
`define CADP_ST_Z         1
`define CADP_ST_OV        2
`define CADP_ST_N         3
`define CADP_ST_DC        8
`define CADP_ST_BUSY      16
`define CADP_ST_ERR       17
`define CADP_RST_FLAGS    5'h00
`define CADP_RST_WORD     16'h0000

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define CADP_OP_ADD       4'h0
`define CADP_OP_SUB       4'h1
`define CADP_OP_AND       4'h2
`define CADP_OP_IOR       4'h3
`define CADP_OP_XOR       4'h4
`define CADP_OP_ASR       4'h5
`define CADP_OP_SL        4'h6
`define CADP_OP_LSR       4'h7
`define CADP_OP_MULSS     4'h8
`define CADP_OP_MULUU     4'h9
`define CADP_OP_MULUS     4'ha
`define CADP_OP_MULSL     4'hb
`define CADP_OP_MULUL     4'hc
`define CADP_OP_MUL8      4'hd
`define CADP_OP_DIVS      4'he
`define CADP_OP_DIVU      4'hf

// ----------------------------------------------------------------
// Divide timing
// ----------------------------------------------------------------
`define CADP_DIV_CYCLES   5'd19
`define CADP_DIV_LAST     5'd18
`define CADP_DIV_FIX      5'd17

`endif

//--- rtl/cadp_alu.v
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "cadp_defs.vh"

module cadp_alu #(
  parameter NREG = 16
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);

  reg  [15:0] wreg [0:NREG-1];
  reg  [31:0] cmd_reg;
  reg         exec_reg;
  reg  [15:0] mem_reg;
  reg  [31:0] result_reg;
  reg         c_reg;
  reg         z_reg;
  reg         ov_reg;
  reg         n_reg;
  reg         dc_reg;
  reg         err_reg;
  reg         busy_reg;
  reg  [4:0]  cnt_reg;
  reg  [15:0] rem_reg;
  reg  [15:0] quo_reg;
  reg  [15:0] dvs_reg;
  reg         negq_reg;
  reg         negr_reg;
  reg         dovf_reg;
  integer     i;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire [3:0]  op     = cmd_reg[`CADP_CMD_OP_LSB +: 4];
  wire        bmode  = cmd_reg[`CADP_CMD_BYTE];
  wire        srcmem = cmd_reg[`CADP_CMD_SRCMEM];
  wire        dstmem = cmd_reg[`CADP_CMD_DSTMEM];
  wire [3:0]  ra     = cmd_reg[`CADP_CMD_RA_LSB +: 4];
  wire [3:0]  rb     = cmd_reg[`CADP_CMD_RB_LSB +: 4];
  wire [3:0]  rd     = cmd_reg[`CADP_CMD_RD_LSB +: 4];
  wire [4:0]  lit    = cmd_reg[`CADP_CMD_LIT_LSB +: 5];
  wire        sticky = cmd_reg[`CADP_CMD_STICKY];
  wire        div32  = cmd_reg[`CADP_CMD_DIV32];
  wire        is_shift = (op == `CADP_OP_ASR) || (op == `CADP_OP_SL) ||
                         (op == `CADP_OP_LSR);
  wire        is_mul = (op[3] == 1'b1) && (op[3:1] != 3'b111);
  wire        is_div = (op[3:1] == 3'b111);

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  // operand source
  wire [15:0] a_raw = srcmem ? mem_reg : wreg[ra];
  wire [15:0] b_raw = wreg[rb];
  wire [15:0] am = bmode ? {8'h00, a_raw[7:0]} : a_raw;
  wire [15:0] bm = bmode ? {8'h00, b_raw[7:0]} : b_raw;
  wire        subop = (op == `CADP_OP_SUB);
  wire [15:0] bx  = subop ? (bm ^ (bmode ? 16'h00ff : 16'hffff)) : bm;
  wire [16:0] sum = {1'b0, am} + {1'b0, bx} + {16'h0000, subop};
  wire [4:0]  nib = {1'b0, am[3:0]} + {1'b0, bx[3:0]} + {4'h0, subop};
  wire [8:0]  lob = {1'b0, am[7:0]} + {1'b0, bx[7:0]} + {8'h00, subop};

  // ----------------------------------------------------------------
  // Barrel shifter
  // ----------------------------------------------------------------
  // single cycle shift
  wire [3:0]  sh  = lit[3:0];
  wire [15:0] asx = bmode ? {{8{a_raw[7]}}, a_raw[7:0]} : a_raw;
  wire [31:0] slx = {16'h0000, am} << sh;
  wire [31:0] srl = {am, 16'h0000} >> sh;
  wire [31:0] sra = $signed({asx, 16'h0000}) >>> sh;

  // ----------------------------------------------------------------
  // Multiplier
  // ----------------------------------------------------------------
  reg  [16:0] ma;
  reg  [16:0] mb;
  always @* begin
    ma = {1'b0, a_raw};
    mb = {1'b0, b_raw};
    case (op)
      `CADP_OP_MULSS: begin
        ma = {a_raw[15], a_raw};
        mb = {b_raw[15], b_raw};
      end
      `CADP_OP_MULUS: mb = {b_raw[15], b_raw};
      `CADP_OP_MULSL: begin
        ma = {a_raw[15], a_raw};
        mb = {12'h000, lit};
      end
      `CADP_OP_MULUL: mb = {12'h000, lit};
      `CADP_OP_MUL8: begin
        ma = {9'h000, a_raw[7:0]};
        mb = {9'h000, b_raw[7:0]};
      end
      default: ma = {1'b0, a_raw};
    endcase
  end
  wire [33:0] prod = $signed(ma) * $signed(mb);

  // ----------------------------------------------------------------
  // Result and flag selection
  // ----------------------------------------------------------------
  reg  [15:0] res;
  reg         c_new;
  reg         arith;
  always @* begin
    res   = 16'h0000;
    c_new = c_reg;
    arith = 1'b0;
    case (op)
      `CADP_OP_ADD, `CADP_OP_SUB: begin
        res   = sum[15:0];
        c_new = bmode ? sum[8] : sum[16];
        arith = 1'b1;
      end
      `CADP_OP_AND: res = am & bm;
      `CADP_OP_IOR: res = am | bm;
      `CADP_OP_XOR: res = am ^ bm;
      `CADP_OP_ASR: begin
        res   = sra[31:16];
        c_new = (sh == 4'h0) ? c_reg : sra[15];
      end
      `CADP_OP_SL: begin
        res   = slx[15:0];
        c_new = (sh == 4'h0) ? c_reg : (bmode ? slx[8] : slx[16]);
      end
      `CADP_OP_LSR: begin
        res   = srl[31:16];
        c_new = (sh == 4'h0) ? c_reg : srl[15];
      end
      default: res = 16'h0000;
    endcase
  end
  wire        rmsb = bmode ? res[7] : res[15];
  wire        amsb = bmode ? am[7] : am[15];
  wire        bmsb = bmode ? bx[7] : bx[15];
  wire        rzero = bmode ? (res[7:0] == 8'h00) : (res == 16'h0000);
  wire        dc_new = bmode ? nib[4] : lob[8];
  wire        ov_new = (amsb == bmsb) && (rmsb != amsb);
  wire        z_new = sticky ? (z_reg & rzero) : rzero;
  wire        bad_shift = is_shift && (srcmem || dstmem);

  // ----------------------------------------------------------------
  // Divide operand preparation
  // ----------------------------------------------------------------
  // signed or unsigned
  wire        dsgn = (op == `CADP_OP_DIVS);
  wire [15:0] dlo = div32 ? wreg[{ra[3:1], 1'b0}] : wreg[ra];
  wire [15:0] dhi = div32 ? wreg[{ra[3:1], 1'b1}] :
                    ((dsgn && dlo[15]) ? 16'hffff : 16'h0000);
  wire [31:0] dd  = {dhi, dlo};
  wire        ddn = dsgn && dd[31];
  wire        dvn = dsgn && b_raw[15];
  wire [31:0] ddm = ddn ? (32'h00000000 - dd) : dd;
  wire [15:0] dvm = dvn ? (16'h0000 - b_raw) : b_raw;
  wire [16:0] trial = {rem_reg, quo_reg[15]};
  wire        fits  = trial >= {1'b0, dvs_reg};
  wire [16:0] diff  = trial - {1'b0, dvs_reg};

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        acc   = psel && penable && pready;
  wire        wacc  = acc && pwrite;
  wire        in_w  = (paddr[7:6] == 2'b01);
  wire [3:0]  widx  = paddr[5:2];
  wire        hit_c = (paddr == `CADP_OFF_CMD);
  wire        hit_s = (paddr == `CADP_OFF_STATUS);
  wire        hit_m = (paddr == `CADP_OFF_MEMDATA);
  wire        hit_r = (paddr == `CADP_OFF_RESULT);
  wire        mapped = hit_c || hit_s || hit_m || hit_r || in_w;
  // Writes that would disturb a running divide are refused.
  wire        refuse = !mapped || (pwrite && busy_reg &&
                       !(hit_c && pwdata[`CADP_CMD_ABORT]) &&
                       (hit_c || hit_m || in_w || hit_s));
  // The access commits what its setup cycle accepted, so a back-to-back
  // write is never dropped silently when busy rises between the two phases.
  wire        abort = wacc && hit_c && pwdata[`CADP_CMD_ABORT] && !pslverr;
  wire        start = wacc && hit_c && !pwdata[`CADP_CMD_ABORT] &&
                      !pslverr;
  reg  [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (in_w) begin
      rd_mux = {16'h0000, wreg[widx]};
    end else if (hit_c) begin
      rd_mux = cmd_reg;
    end else if (hit_s) begin
      rd_mux[`CADP_ST_C]    = c_reg;
      rd_mux[`CADP_ST_Z]    = z_reg;
      rd_mux[`CADP_ST_OV]   = ov_reg;
      rd_mux[`CADP_ST_N]    = n_reg;
      rd_mux[`CADP_ST_DC]   = dc_reg;
      rd_mux[`CADP_ST_BUSY] = busy_reg;
      rd_mux[`CADP_ST_ERR]  = err_reg;
    end else if (hit_m) begin
      rd_mux = {16'h0000, mem_reg};
    end else if (hit_r) begin
      rd_mux = result_reg;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave: one wait-free access cycle after setup.
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
      pslverr <= psel && !penable && refuse;
    end
  end

  // ----------------------------------------------------------------
  // Command, divide sequencer and flags
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      cmd_reg    <= 32'h00000000;
      exec_reg   <= 1'b0;
      busy_reg   <= 1'b0;
      cnt_reg    <= 5'd0;
      rem_reg    <= `CADP_RST_WORD;
      quo_reg    <= `CADP_RST_WORD;
      dvs_reg    <= `CADP_RST_WORD;
      negq_reg   <= 1'b0;
      negr_reg   <= 1'b0;
      dovf_reg   <= 1'b0;
      result_reg <= 32'h00000000;
      {dc_reg, n_reg, ov_reg, z_reg, c_reg} <= `CADP_RST_FLAGS;
      err_reg    <= 1'b0;
    end else begin
      exec_reg <= start;
      if (start) begin
        cmd_reg <= pwdata;
      end
      // Software flag writes lose to a same-cycle hardware update.
      if (wacc && hit_s && !pslverr) begin
        c_reg   <= pwdata[`CADP_ST_C];
        z_reg   <= pwdata[`CADP_ST_Z];
        ov_reg  <= pwdata[`CADP_ST_OV];
        n_reg   <= pwdata[`CADP_ST_N];
        dc_reg  <= pwdata[`CADP_ST_DC];
        err_reg <= pwdata[`CADP_ST_ERR];
      end
      if (abort) begin
        busy_reg <= 1'b0;
      end else if (exec_reg && is_div) begin
        busy_reg <= 1'b1;
        cnt_reg  <= 5'd0;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 5'd1;
        if (cnt_reg == 5'd0) begin
          rem_reg  <= ddm[31:16];
          quo_reg  <= ddm[15:0];
          dvs_reg  <= dvm;
          negq_reg <= ddn ^ dvn;
          negr_reg <= ddn;
          dovf_reg <= (dvm == 16'h0000) || (ddm[31:16] >= dvm);
        end else if (cnt_reg < `CADP_DIV_FIX) begin
          rem_reg <= fits ? diff[15:0] : trial[15:0];
          quo_reg <= {quo_reg[14:0], fits};
        end else if (cnt_reg == `CADP_DIV_FIX) begin
          quo_reg <= negq_reg ? (16'h0000 - quo_reg) : quo_reg;
          rem_reg <= negr_reg ? (16'h0000 - rem_reg) : rem_reg;
        end else begin
          busy_reg   <= 1'b0;
          result_reg <= {rem_reg, quo_reg};
          ov_reg     <= dovf_reg;
          z_reg      <= (quo_reg == 16'h0000);
          n_reg      <= quo_reg[15];
        end
      end
      if (exec_reg && !is_div) begin
        if (bad_shift) begin
          err_reg <= 1'b1;
        end else if (is_mul) begin
          result_reg <= prod[31:0];
        end else begin
          result_reg <= {16'h0000, res};
          z_reg      <= z_new;
          n_reg      <= rmsb;
          c_reg      <= c_new;
          if (arith) begin
            ov_reg <= ov_new;
            dc_reg <= dc_new;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Working registers and memory operand
  // ----------------------------------------------------------------
  // Byte results replace only the low byte, as byte loads do.
  wire [15:0] wold = dstmem ? mem_reg : wreg[rd];
  wire [15:0] wval = bmode ? {wold[15:8], res[7:0]} : res;
  always @(posedge clock) begin
    if (reset) begin
      mem_reg <= `CADP_RST_WORD;
      for (i = 0; i < NREG; i = i + 1) begin
        wreg[i] <= `CADP_RST_WORD;
      end
    end else begin
      if (wacc && !pslverr && in_w) begin
        wreg[widx] <= pwdata[15:0];
      end
      if (wacc && !pslverr && hit_m) begin
        mem_reg <= pwdata[15:0];
      end
      if (exec_reg && !is_div && !bad_shift) begin
        if (is_mul) begin
          wreg[{rd[3:1], 1'b0}] <= prod[15:0];
          wreg[{rd[3:1], 1'b1}] <= prod[31:16];
        end else if (dstmem) begin
          mem_reg <= wval;
        end else begin
          wreg[rd] <= wval;
        end
      end
      if (busy_reg && !abort && cnt_reg == `CADP_DIV_LAST) begin
        wreg[0] <= quo_reg;
        wreg[1] <= rem_reg;
      end
    end
  end

endmodule

//--- verification/cadp_alu_chk.sv
`timescale 1ns/1ps
module cadp_alu_chk #(
  parameter NREG = 16
) (
  input logic        clock,
  input logic        reset,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Transfer phases
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence

  // An accepted divide command; abort commands are left out on purpose.
  sequence s_div_cmd;
    pready && pwrite && !pslverr && paddr == 8'h00 &&
    pwdata[3:1] == 3'b111 && !pwdata[31];
  endsequence

  // ----------------------------------------------------------------
  // Bus answer timing
  // ----------------------------------------------------------------
  a_ready_after_setup: assert property (s_setup |=> pready && penable)
    else $error("pready missing in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access cycle");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error without pready");

  // ----------------------------------------------------------------
  // Decode and refusal
  // ----------------------------------------------------------------
  a_unmapped_err: assert property (s_setup ##0 (paddr >= 8'h10 &&
    paddr < 8'h40) |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_read_ok: assert property (s_setup ##0 (!pwrite &&
    paddr[1:0] == 2'b00 && (paddr < 8'h10 ||
    (paddr >= 8'h40 && paddr < 8'h40 + 4 * NREG))) |=> !pslverr)
    else $error("mapped read refused");
  a_wreg_upper_zero: assert property (pready && !pwrite &&
    paddr >= 8'h40 |-> prdata[31:16] == 16'h0)
    else $error("working register upper half not zero");
  a_busy_refuse: assert property (s_div_cmd ##2
    (psel && !penable && pwrite && paddr >= 8'h40) |=> pslverr)
    else $error("register write accepted while divide busy");
endmodule

//--- verification/cadp_apb_host.sv
`timescale 1ns/1ps
module cadp_apb_host (
  input  logic        clock,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  // The bus is idle with every request line low from time zero.
  initial {psel, penable, pwrite, paddr, pwdata} = '0;

  // ----------------------------------------------------------------
  // One transfer, setup then access until pready
  // ----------------------------------------------------------------
  // The request is held until pready is seen at a rising edge, so a slow
  // slave is served as well as a prompt one; only the bench timeout ends it.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

//--- verification/cpu_alu_mul_div_shift_tb.sv
`timescale 1ns/1ps
`include "cadp_defs.vh"
module cpu_alu_mul_div_shift_tb;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  wire         psel, penable, pwrite, pready, pslverr;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata, prdata;
  integer      fail_count = 0;
  integer      n_checks = 0;
  integer      cyc = 0;
  logic [31:0] q;
  logic        e;
  logic [31:0] mexp [0:5] = '{32'h00000006, 32'hfffb0006, 32'hfffd0006,
                              32'hfffffff6, 32'h0004fff6, 32'h0000fb06};
  logic [31:0] sexp [0:2] = '{32'h0000ffff, 32'h00008000, 32'h00000001};

  // Free-running clock, 40 ns period.
  always #20 clock = ~clock;

  cadp_alu #(.NREG(16)) DUT (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  cadp_apb_host u_host (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0, q, e);
    chk(name, exp, q);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset_values;
    rd("status at reset", `CADP_OFF_STATUS, 32'h0);
    rd("w0 at reset", `CADP_OFF_WREG, 32'h0);
  endtask

  // Word add across the sign boundary raises overflow and digit carry.
  task t_add_word;
    wr(8'h44, 32'h7fff);
    wr(8'h48, 32'h0001);
    wr(`CADP_OFF_CMD, 32'h00032100);
    rd("add result", 8'h4c, 32'h8000);
    rd("add flags", `CADP_OFF_STATUS, 32'h10c);
  endtask

  // Byte subtract with a borrow; the upper byte of the target must stay.
  task t_sub_byte;
    wr(8'h44, 32'h0010);
    wr(8'h48, 32'h0020);
    wr(8'h50, 32'habcd);
    wr(`CADP_OFF_CMD, 32'h00042111);
    rd("byte sub result", 8'h50, 32'habf0);
    rd("sub flags", `CADP_OFF_STATUS, 32'h108);
  endtask

  // A zero result leaves a clear zero flag alone only in sticky mode.
  task t_sticky_zero;
    wr(`CADP_OFF_STATUS, 32'h0);
    wr(`CADP_OFF_CMD, 32'h02031104);
    rd("sticky zero", `CADP_OFF_STATUS, 32'h0);
    wr(`CADP_OFF_CMD, 32'h00031104);
    rd("plain zero", `CADP_OFF_STATUS, 32'h2);
    wr(`CADP_OFF_CMD, 32'h02031104);
    rd("sticky zero kept", `CADP_OFF_STATUS, 32'h2);
    wr(`CADP_OFF_CMD, 32'h02032104);
    rd("sticky nonzero", `CADP_OFF_STATUS, 32'h0);
  endtask

  // Every multiply mode on operands whose sign reading changes the product.
  task t_mul_modes;
    wr(8'h44, 32'hfffe);
    wr(8'h48, 32'hfffd);
    for (int i = 0; i < 6; i++) begin
      wr(`CADP_OFF_CMD, 32'h00562100 | (32'h8 + i));
      rd("product", `CADP_OFF_RESULT, mexp[i]);
    end
    rd("product low reg", 8'h58, 32'hfb06);
  endtask

  // Fifteen-place shifts in all three kinds, then a refused memory operand.
  task t_shifts;
    wr(8'h44, 32'h8001);
    for (int i = 0; i < 3; i++) begin
      wr(`CADP_OFF_CMD, 32'h00f30100 | (32'h5 + i));
      rd("shift result", 8'h4c, sexp[i]);
    end
    wr(`CADP_OFF_CMD, 32'h00f30125);
    u_host.xfer(1'b0, `CADP_OFF_STATUS, 32'h0, q, e);
    chk("shift mem error", 32'h1, {31'h0, q[17]});
    rd("shift mem no effect", 8'h4c, 32'h0001);
    wr(`CADP_OFF_STATUS, 32'h0);
  endtask

  // Signed 32/16 divide from the pair W2:W3, with a write refused meanwhile.
  task t_divide;
    wr(8'h48, 32'h7960);
    wr(8'h4c, 32'hfffe);
    wr(8'h54, 32'h0007);
    wr(`CADP_OFF_CMD, 32'h0400520e);
    wr(8'h54, 32'h0999);
    chk("write while busy", 32'h1, {31'h0, e});
    repeat (14) @(posedge clock);
    u_host.xfer(1'b0, `CADP_OFF_STATUS, 32'h0, q, e);
    chk("busy late", 32'h1, {31'h0, q[16]});
    u_host.xfer(1'b0, `CADP_OFF_STATUS, 32'h0, q, e);
    chk("busy done", 32'h0, {31'h0, q[16]});
    rd("quotient", `CADP_OFF_WREG, 32'hc833);
    rd("remainder", 8'h44, 32'hfffb);
    rd("divisor kept", 8'h54, 32'h0007);
    rd("div flags", `CADP_OFF_STATUS, 32'h8);
  endtask

  // An aborted divide writes nothing; a 16/16 unsigned one then runs whole.
  task t_div_abort;
    wr(`CADP_OFF_CMD, 32'h0000520f);
    wr(`CADP_OFF_CMD, 32'h80000000);
    chk("abort accepted", 32'h0, {31'h0, e});
    rd("status after abort", `CADP_OFF_STATUS, 32'h8);
    repeat (20) @(posedge clock);
    rd("w0 after abort", `CADP_OFF_WREG, 32'hc833);
    wr(`CADP_OFF_CMD, 32'h0000520f);
    q = 32'h00010000;
    while (q[16]) u_host.xfer(1'b0, `CADP_OFF_STATUS, 32'h0, q, e);
    rd("short quotient", `CADP_OFF_WREG, 32'h1156);
    rd("short remainder", 8'h44, 32'h0006);
  endtask

  // The memory stand-in serves as both source and destination of an add.
  task t_mem_operand;
    wr(`CADP_OFF_MEMDATA, 32'h1234);
    wr(`CADP_OFF_CMD, 32'h00002060);
    rd("memory result", `CADP_OFF_MEMDATA, 32'h8b94);
    rd("w0 untouched", `CADP_OFF_WREG, 32'h1156);
  endtask

  task t_unmapped;
    u_host.xfer(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask

  // ----------------------------------------------------------------
  // Verdict and hang guard
  // ----------------------------------------------------------------
  task report_and_stop;
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    t_reset_values;
    t_add_word;
    t_sub_byte;
    t_sticky_zero;
    t_mul_modes;
    t_shifts;
    t_divide;
    t_div_abort;
    t_mem_operand;
    t_unmapped;
    report_and_stop;
  end
endmodule

bind cadp_alu cadp_alu_chk #(.NREG(NREG)) u_chk (.clock(clock),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
